// *** core/ltc_regs.sv ***
// Purpose: write-only control and diagnostic registers of the line transceiver
// Assumes: bytes arrive from the serial control channel once per frame
// Notes: outputs are the decoded fields steering the transceiver datapath
`include "ltc_consts.svh"
module ltc_regs
  import ltc_pkg::*;
#(
  parameter int FRAME_NS = `LTC_FRAME_NS
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial control channel pins
  input wire logic frame_pulse_i,
  input wire logic bit_clk_i,
  input wire logic control_data_input_pin_i,
  // dual-port operation strap, level
  input wire logic dual_port_i,
  // decoded control fields
  output logic rate_select_o,
  output logic d_in_b_slot_o,
  output logic [1:0] d_bits_used_o,
  output logic scrambler_enable_o,
  output logic converge_speedup_o,
  output logic tx_housekeeping_o,
  // decoded diagnostic fields
  output ltc_loop_t loopback_o,
  output logic polynomial_swap_o,
  output logic line_out_disable_o,
  output logic default_mode_o,
  // raw register images
  output logic [7:0] line_control_o,
  output logic [7:0] line_diagnostics_o
);

  ltc_byte_if bus ();
  logic cd_level;
  logic dual_sync1;
  logic dual_sync2;
  logic [7:0] line_control;
  logic [7:0] line_diagnostics;
  logic drr_pending;
  ltc_wr_t wr_kind;
  logic [7:0] next_control;
  logic [7:0] next_diag;

  // ==========================================================
  // serial channel front end
  ltc_cchan_rx u_rx
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_pulse_i(frame_pulse_i),
    .bit_clk_i(bit_clk_i),
    .control_data_input_pin_i(control_data_input_pin_i),
    .cd_level_o(cd_level),
    .byte_o(bus)
  );

  // strap comes from a pin, so it is synchronised too
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dual_sync1 <= 1'b0;
      dual_sync2 <= 1'b0;
    end
    else
    begin
      dual_sync1 <= dual_port_i;
      dual_sync2 <= dual_sync1;
    end
  end

  // ==========================================================
  // classify the incoming byte
  always_comb
  begin
    wr_kind = ltc_wr_none;
    if (bus.valid && bus.data[1:0] == `LTC_SEL_CONTROL)
    begin
      if (&bus.data[7:4])
        wr_kind = ltc_wr_default;
      else
        wr_kind = ltc_wr_control;
    end
    else if (bus.valid && bus.data[1:0] == `LTC_SEL_DIAG)
    begin
      if (&bus.data[7:4])
        wr_kind = ltc_wr_default;
      else
        wr_kind = ltc_wr_diag;
    end
  end

  // next register images; default mode overrides normal field meaning
  always_comb
  begin
    next_control = line_control;
    next_diag = line_diagnostics;
    if (dual_sync2)
    begin
      // pin level continuously selects a default mode, no write needed
      next_control = cd_level ? `LTC_DEF2_CTL : `LTC_DEF1_CTL;
      next_diag = `LTC_DEF_DIAG;
    end
    else
    begin
      case (wr_kind)
        ltc_wr_default:
        begin
          next_control = bus.data[3] ? `LTC_DEF2_CTL : `LTC_DEF1_CTL;
          next_diag = `LTC_DEF_DIAG;
        end
        ltc_wr_control:
          next_control = bus.data;
        ltc_wr_diag:
          next_diag = bus.data;
        default:
        begin
          next_control = line_control;
          next_diag = line_diagnostics;
        end
      endcase
      // a pending reset wins at the frame pulse unless a diagnostic write lands in the same cycle
      if (bus.frame && drr_pending && wr_kind != ltc_wr_diag)
        next_diag = `LTC_DIAG_RESET;
    end
  end

  // ==========================================================
  // register state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_control <= `LTC_CTL_RESET;
      line_diagnostics <= `LTC_DIAG_RESET;
    end
    else
    begin
      line_control <= next_control;
      line_diagnostics <= next_diag;
    end
  end

  // diagnostic reset request armed by a control write with bit 2 low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      drr_pending <= 1'b0;
    else if (!dual_sync2 && wr_kind == ltc_wr_control)
      drr_pending <= !bus.data[`LTC_CTL_DRR];
    else if (bus.frame)
      drr_pending <= 1'b0;
  end

  // ==========================================================
  // decoded outputs, registered so each comes straight from a flip-flop
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rate_select_o <= 1'b0;
      d_in_b_slot_o <= 1'b0;
      d_bits_used_o <= 2'h1;
      scrambler_enable_o <= 1'b0;
      converge_speedup_o <= 1'b0;
      tx_housekeeping_o <= 1'b0;
      loopback_o <= ltc_lb_none;
      polynomial_swap_o <= 1'b0;
      line_out_disable_o <= 1'b0; // reset diag image leaves the line output on
      default_mode_o <= 1'b0;
      line_control_o <= `LTC_CTL_RESET;
      line_diagnostics_o <= `LTC_DIAG_RESET;
    end
    else
    begin
      rate_select_o <= next_control[`LTC_CTL_RATE];
      d_in_b_slot_o <= next_control[`LTC_CTL_D_IN_B_SLOT];
      // D bits per frame outside the B slot: D0 alone, or D0 and D1
      if (next_control[`LTC_CTL_D_IN_B_SLOT])
        d_bits_used_o <= 2'h0;
      else
        d_bits_used_o <= next_control[`LTC_CTL_RATE] ? 2'h2 : 2'h1;
      scrambler_enable_o <= next_control[`LTC_CTL_SCR];
      // speed-up hold length is the controller's job; the block only follows
      converge_speedup_o <= next_control[`LTC_CTL_SPEED];
      tx_housekeeping_o <= next_control[`LTC_CTL_HK];
      loopback_o <= ltc_loop_t'({next_diag[`LTC_DIAG_LB_LO], next_diag[`LTC_DIAG_LB_HI]});
      polynomial_swap_o <= next_diag[`LTC_DIAG_SWAP];
      line_out_disable_o <= next_diag[`LTC_DIAG_LOD];
      default_mode_o <= dual_sync2 || (wr_kind == ltc_wr_default) ||
        (default_mode_o && wr_kind == ltc_wr_none);
      line_control_o <= next_control;
      line_diagnostics_o <= next_diag;
    end
  end

endmodule // ltc_regs

// *** core/ltc_consts.svh ***
// Purpose: constants for the line transceiver control register pair
// Assumes: control-channel bytes carry bit 0 first as the lsb of an 8-bit word
// Notes: field positions, default-mode images and timing figures
`ifndef LTC_CONSTS_SVH
`define LTC_CONSTS_SVH

// ==========================================================
// register select field (bits 1:0 of a control-channel byte)
`define LTC_SEL_CONTROL 2'b00
`define LTC_SEL_DIAG 2'b10

// ==========================================================
// control register field positions
`define LTC_CTL_DRR 2
`define LTC_CTL_RATE 3
`define LTC_CTL_D_IN_B_SLOT 4
`define LTC_CTL_SCR 5
`define LTC_CTL_SPEED 6
`define LTC_CTL_HK 7

// ==========================================================
// diagnostic register field positions
`define LTC_DIAG_LB_LO 2
`define LTC_DIAG_LB_HI 3
`define LTC_DIAG_MODESEL 3
`define LTC_DIAG_SWAP 5
`define LTC_DIAG_LOD 6

// ==========================================================
// default-mode images and reset values, as bit 7..0 values of bit-0-first strings
// default two sets only the rate bit; the diag image keeps just its select bit
`define LTC_DEF1_CTL 8'h00
`define LTC_DEF2_CTL 8'h08
`define LTC_DEF_DIAG 8'h02
`define LTC_CTL_RESET 8'h00
`define LTC_DIAG_RESET 8'h02

// ==========================================================
// timing: convergence speed-up hold recommended to the controller
`define LTC_SPEEDUP_FRAMES_160 240
`define LTC_SPEEDUP_FRAMES_80 480
`define LTC_FRAME_NS 125000

`endif

// *** core/ltc_pkg.sv ***
// Purpose: types for the line transceiver control register pair
// Assumes: nothing beyond the constants header
// Notes: loopback path encoding and register write record
package ltc_pkg;

  // ==========================================================
  // loopback selection, coded {bit2,bit3} order of the diagnostic register
  typedef enum logic [1:0]
  {
    ltc_lb_none,
    ltc_lb_sys_in_to_out,
    ltc_lb_line,
    ltc_lb_sys_out_to_in
  } ltc_loop_t;

  // ==========================================================
  // kinds of write decoded from each incoming byte
  typedef enum logic [1:0]
  {
    ltc_wr_none,
    ltc_wr_control,
    ltc_wr_diag,
    ltc_wr_default
  } ltc_wr_t;

endpackage

// *** core/ltc_byte_if.sv ***
// Purpose: carries one decoded control-channel byte between modules
// Assumes: single clock, strobe is one cycle
// Notes: the shifter drives, the register bank consumes
interface ltc_byte_if;
  logic valid;
  logic [7:0] data;
  logic frame;

  modport src
  (
    output valid,
    output data,
    output frame
  );
  modport dst
  (
    input valid,
    input data,
    input frame
  );
endinterface

// *** core/ltc_cchan_rx.sv ***
// Purpose: samples frame pulse, bit clock and control data, assembles a byte
// Assumes: frame pulse marks channel start; data valid on rising bit clock
// Notes: all pins pass two flip-flops before any logic reads them
module ltc_cchan_rx
  import ltc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial control channel pins
  input wire logic frame_pulse_i,
  input wire logic bit_clk_i,
  input wire logic control_data_input_pin_i,
  // synchronised pin level for dual-port default selection
  output logic cd_level_o,
  // assembled byte
  ltc_byte_if.src byte_o
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic bclk_d;
  logic fp_d;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic armed;

  // ==========================================================
  // two-stage synchronisers; stage one is read only by stage two
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end
    else
    begin
      sync1 <= {control_data_input_pin_i, bit_clk_i, frame_pulse_i};
      sync2 <= sync1;
    end
  end

  // edge history from the second stage only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bclk_d <= 1'b0;
      fp_d <= 1'b0;
    end
    else
    begin
      bclk_d <= sync2[1];
      fp_d <= sync2[0];
    end
  end

  assign cd_level_o = sync2[2];

  // ==========================================================
  // shift in eight bits after each frame pulse, bit 0 arrives first
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      armed <= 1'b0;
      byte_o.valid <= 1'b0;
      byte_o.data <= 8'h00;
    end
    else
    begin
      byte_o.valid <= 1'b0;
      if (sync2[0] && !fp_d)
      begin
        bit_cnt <= 3'h0;
        armed <= 1'b1;
      end
      else if (armed && sync2[1] && !bclk_d)
      begin
        shreg <= {sync2[2], shreg[7:1]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          armed <= 1'b0; // one byte per frame; later bits are other channels
          byte_o.valid <= 1'b1;
          byte_o.data <= {sync2[2], shreg[7:1]};
        end
      end
    end
  end

  // frame strobe, one cycle at each rising frame pulse
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      byte_o.frame <= 1'b0;
    else
      byte_o.frame <= sync2[0] && !fp_d;
  end

endmodule // ltc_cchan_rx

// *** tb/ltc_regs_chk_assertions.sv ***
// Purpose: port-level checks of the line transceiver registers
// Assumes: field outputs move in the same cycle as the images
// Notes: bound to ltc_regs; dual checks allow for pin sync delay
module ltc_regs_chk
  import ltc_pkg::*;
(
  // clock, reset and straps
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dual_port_i,
  input wire logic control_data_input_pin_i,
  // decoded fields
  input wire logic rate_select_o,
  input wire logic d_in_b_slot_o,
  input wire logic [1:0] d_bits_used_o,
  input wire logic scrambler_enable_o,
  input wire logic converge_speedup_o,
  input wire logic tx_housekeeping_o,
  input wire ltc_loop_t loopback_o,
  input wire logic polynomial_swap_o,
  input wire logic line_out_disable_o,
  // register images
  input wire logic [7:0] line_control_o,
  input wire logic [7:0] line_diagnostics_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // decoded fields follow their images
  rate_sel_a: assert property (rate_select_o == line_control_o[3])
    else $error("rate field off");
  d_slot_a: assert property (d_in_b_slot_o == line_control_o[4])
    else $error("d slot field off");
  d_bits_a: assert property (d_bits_used_o == (d_in_b_slot_o ? 2'd0 :
    (rate_select_o ? 2'd2 : 2'd1))) else $error("d bit count off");
  scr_en_a: assert property (scrambler_enable_o == line_control_o[5])
    else $error("scrambler field off");
  speedup_a: assert property (converge_speedup_o == line_control_o[6])
    else $error("speed-up field off");
  hk_bit_a: assert property (tx_housekeeping_o == line_control_o[7])
    else $error("housekeeping field off");
  loop_sel_a: assert property (loopback_o == {line_diagnostics_o[2],
    line_diagnostics_o[3]}) else $error("loopback code off");
  poly_swap_a: assert property (polynomial_swap_o == line_diagnostics_o[5])
    else $error("swap field off");
  line_output_dis_a: assert property (line_out_disable_o == line_diagnostics_o[6])
    else $error("line out field off");
  // all-ones upper nibble never survives as a plain write
  ctl_def_a: assert property (line_control_o[7:4] != 4'hf)
    else $error("control default missed");
  diag_def_a: assert property (line_diagnostics_o[7:4] != 4'hf)
    else $error("diag default missed");
  // steady strap and pin must settle on a default image
  dual_def_a: assert property ((dual_port_i && $stable(control_data_input_pin_i)) [*8]
    |-> line_control_o == {4'h0, control_data_input_pin_i, 3'b000}
    && line_diagnostics_o == 8'h02) else $error("dual default off");
  cover property (dual_port_i [*8]);
  cover property (loopback_o == ltc_lb_sys_out_to_in);
  cover property (line_control_o == 8'h08);
endmodule // ltc_regs_chk

bind ltc_regs ltc_regs_chk chk (.*);

// *** tb/ltc_cchan_ctrl.sv ***
// Purpose: system controller model on the serial control channel
// Assumes: called at a rising clock edge
// Notes: bit clock idles low between frames; data shows a flipped value
module ltc_cchan_ctrl
(
  // clock
  input wire logic clk_i,
  // channel pins toward the device
  output logic frame_o,
  output logic bclk_o,
  output logic cdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {frame_o, bclk_o, cdata_o} = 3'b000;
  // one frame: pulse, then eight bits lsb first, each 4 clk low, 4 high
  task automatic send(input logic [7:0] b);
    frame_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    frame_o <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      cdata_o <= b[i];
      bclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      bclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    bclk_o <= 1'b0;
    cdata_o <= ~b[7]; // released line must not look held
    repeat (8) @(posedge clk_i);
  endtask
  // static pin level for dual-port default selection
  task automatic level(input logic v);
    cdata_o <= v;
  endtask
endmodule // ltc_cchan_ctrl

// *** tb/tb.sv ***
// Purpose: self-checking bench for the line transceiver registers
// Assumes: one byte per frame through the controller model
// Notes: images and default-mode flag checked through a queue of expected triples
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD_160 = 3; // scaled down from 240 frames
  localparam int HOLD_80 = 6; // scaled down from 480 frames
  logic clk_i = 0, rst_i = 1, dual_port_i = 0;
  logic frame_pulse_i, bit_clk_i, control_data_input_pin_i;
  logic rate_select_o, d_in_b_slot_o, scrambler_enable_o, converge_speedup_o;
  logic tx_housekeeping_o, polynomial_swap_o, line_out_disable_o, default_mode_o;
  logic [1:0] d_bits_used_o;
  ltc_pkg::ltc_loop_t loopback_o;
  logic [7:0] line_control_o, line_diagnostics_o, ectl = 0, ediag = 8'h02;
  logic diag_reg_reset = 0, edm = 0;
  logic [16:0] q[$];
  int errors = 0, total_checks = 0, cycles = 0;
  event due;
  ltc_regs dut (.*);
  ltc_cchan_ctrl m (.clk_i(clk_i), .frame_o(frame_pulse_i), .bclk_o(bit_clk_i),
    .cdata_o(control_data_input_pin_i));
  always #2.5 clk_i = ~clk_i;
  // ==========================================================
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // model one byte, send it, then queue the expected images
  task automatic xfer(input logic [7:0] b);
    // an armed diag reset fires once, at this frame's pulse, before the byte lands
    if (diag_reg_reset)
    begin
      ediag = 8'h02;
      diag_reg_reset = 1'b0;
    end
    if (b[7:4] == 4'hf && !b[0])
    begin
      ectl = {4'h0, b[3], 3'b000};
      ediag = 8'h02;
      edm = 1'b1;
    end
    else if (b[1:0] == 2'b00)
    begin
      ectl = b;
      diag_reg_reset = !b[2];
      edm = 1'b0;
    end
    else if (b[1:0] == 2'b10)
    begin
      ediag = b;
      edm = 1'b0;
    end
    m.send(b);
    q.push_back({edm, ectl, ediag});
    -> due;
  endtask
  task automatic dual(input logic v);
    dual_port_i <= 1'b1;
    m.level(v);
    repeat (12) @(posedge clk_i);
    {edm, ectl, ediag} = {1'b1, 4'h0, v, 3'b000, 8'h02};
    q.push_back({edm, ectl, ediag});
    -> due;
    @(posedge clk_i);
    dual_port_i <= 1'b0;
    // let the low level stand one edge so a following call does not re-drive it
    @(posedge clk_i);
  endtask
  // monitor: one settled comparison per queued note
  initial forever
  begin
    @(due);
    #1;
    check({default_mode_o, line_control_o, line_diagnostics_o}, q.pop_front());
  end
  initial
  begin
    void'($urandom(32'h2c1c_9b3a));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    q.push_back(17'h0_0002);
    -> due;
    @(posedge clk_i);
    xfer(8'h04);
    // every loopback code, swap and line-out combinations
    for (int k = 0; k < 4; k++) xfer({1'b0, k[1], k[0], 1'b0, k[1:0], 2'b10});
    xfer(8'h00);
    xfer(8'h03);
    xfer(8'h59);
    for (int k = 0; k < 2; k++)
    begin
      xfer({4'hf, k[0], 3'b100});
      xfer({4'hf, k[0], 3'b010});
      // speed-up held after power-up, then dropped
      repeat (k ? HOLD_160 : HOLD_80) xfer({4'h4, k[0], 3'b100});
      xfer({4'h0, k[0], 3'b100});
    end
    repeat (24) xfer(8'($urandom()));
    dual(1'b0);
    dual(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    {diag_reg_reset, edm, ectl, ediag} = {2'b00, 16'h0002};
    q.push_back(17'h0_0002);
    -> due;
    @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(8'hb8);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule // tb
